/* File: logic/wlec_defines.svh */
// Constants for the write latch and erase sequencer
`ifndef WLEC_DEFINES_SVH
`define WLEC_DEFINES_SVH
`define WLEC_OP_WREN 8'h06
`define WLEC_OP_WRDI 8'h04
`define WLEC_OP_SSE 8'h20
`define WLEC_OP_SE 8'hd8
`define WLEC_OP_BE 8'hc7
`define WLEC_OP_SUSP 8'h75
`define WLEC_OP_RESM 8'h7a
`define WLEC_OP_CLFS 8'h50
`define WLEC_ADDR_BITS 24
`define WLEC_FLAG_RESET 8'h80
`define WLEC_FLAG_READY 7
`define WLEC_FLAG_ESUSP 6
`define WLEC_FLAG_EERR 5
`define WLEC_FLAG_PROT 1
`define WLEC_MODE_EXT 2'h0
`define WLEC_MODE_DUAL 2'h1
`define WLEC_MODE_QUAD 2'h2
`define WLEC_CLK_MHZ 50
`define WLEC_SSE_TIME_US 64
`define WLEC_SE_TIME_US 256
`define WLEC_BE_TIME_US 4096
`define WLEC_TIMEOUT_US 8192
`define WLEC_SSE_CYC (`WLEC_SSE_TIME_US * `WLEC_CLK_MHZ)
`define WLEC_SE_CYC (`WLEC_SE_TIME_US * `WLEC_CLK_MHZ)
`define WLEC_BE_CYC (`WLEC_BE_TIME_US * `WLEC_CLK_MHZ)
`define WLEC_TIMEOUT_CYC (`WLEC_TIMEOUT_US * `WLEC_CLK_MHZ)
`endif

/* File: logic/wlec_pkg.sv */
// Types for the write latch and erase sequencer
package wlec_pkg;
	typedef enum logic [1:0] {WLEC_IDLE, WLEC_BUSY, WLEC_SUSP} wlec_op_state_t;
	typedef enum logic [1:0] {WLEC_NONE, WLEC_SSE, WLEC_SE, WLEC_BE} wlec_erase_kind_t;
	typedef struct packed {
		logic erase_start;
		wlec_erase_kind_t kind;
		logic [23:0] addr;
	} wlec_erase_req_t;
	typedef struct packed {
		logic [1:0] sclk_s;
		logic [1:0] csn_s;
		logic [7:0] dq_s;
	} wlec_sync_t;
endpackage : wlec_pkg

/* File: logic/wlec_frame_rx.sv */
// Serial frame receiver: opcode and address shifting per lane mode
`timescale 1ns/10ps
`include "wlec_defines.svh"
module wlec_frame_rx (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic sclk_rise,
	input wire logic frame_open,
	input wire logic [3:0] dq_in,
	input wire logic [1:0] lane_mode,
	output logic [7:0] opcode,
	output logic [23:0] addr,
	output logic [5:0] bit_count
);
	typedef struct packed {
		logic [31:0] shift;
		logic [5:0] cnt;
	} wlec_rx_state_t;
	wlec_rx_state_t q, d;
	logic [2:0] step;
	always_comb
	begin
		d = q;
		step = 3'h1;
		if (lane_mode == `WLEC_MODE_DUAL)
			step = 3'h2;
		else if (lane_mode == `WLEC_MODE_QUAD)
			step = 3'h4;
		if (!frame_open)
		begin
			d.cnt = 6'h0;
			d.shift = 32'h0;
		end
		else if (sclk_rise && q.cnt < 6'h20)
		begin
			case (step)
				3'h2: d.shift = {q.shift[29:0], dq_in[1:0]};
				3'h4: d.shift = {q.shift[27:0], dq_in};
				default: d.shift = {q.shift[30:0], dq_in[0]};
			endcase
			d.cnt = q.cnt + 6'(step);
		end
	end
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			q <= '0;
		else
			q <= d;
	end
	assign bit_count = q.cnt;
	assign opcode = (q.cnt > 6'h8) ? q.shift[31:24] : q.shift[7:0];
	assign addr = q.shift[23:0];
endmodule : wlec_frame_rx

/* File: logic/wlec_top.sv */
// Write enable latch and erase command sequencer
`timescale 1ns/10ps
`include "wlec_defines.svh"
// ==========================================
module wlec_top #(
	parameter int unsigned SSE_CYC = `WLEC_SSE_CYC,
	parameter int unsigned SE_CYC = `WLEC_SE_CYC,
	parameter int unsigned BE_CYC = `WLEC_BE_CYC,
	parameter int unsigned TIMEOUT_CYC = `WLEC_TIMEOUT_CYC
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic serial_clk,
	input wire logic chip_sel_n,
	input wire logic [3:0] serial_lane,
	input wire logic [1:0] lane_mode,
	input wire logic region_protected,
	input wire logic any_sector_locked,
	input wire logic erase_fault,
	output logic write_enable_latch,
	output logic write_in_progress,
	output logic [7:0] flag_status,
	output logic erase_pulse,
	output logic [1:0] erase_kind,
	output logic [23:0] erase_addr
);
	// ==========================================
	// State
	typedef struct packed {
		wlec_pkg::wlec_sync_t sync;
		logic sclk_last;
		logic csn_last;
		logic wel;
		logic wip;
		logic [7:0] flags;
		wlec_pkg::wlec_op_state_t st;
		wlec_pkg::wlec_erase_req_t req;
		logic [31:0] remain;
		logic [31:0] age;
		logic erase_pulse;
	} wlec_top_state_t;
	wlec_top_state_t q, d;
	logic [7:0] opcode;
	logic [23:0] addr;
	logic [5:0] bits;
	logic sclk_rise;
	logic frame_open;
	logic frame_end;
	logic [5:0] abits;
	logic op_only;
	logic addressed;
	// ==========================================
	// Receiver
	assign sclk_rise = q.sync.sclk_s[1] && !q.sclk_last;
	assign frame_open = !q.sync.csn_s[1];
	assign frame_end = q.sync.csn_s[1] && !q.csn_last;
	wlec_frame_rx wlec_frame_rx_inst (
		.clock(clock),
		.sys_rst(sys_rst),
		.sclk_rise(sclk_rise),
		.frame_open(frame_open),
		// Second sync stage only; first stage may be metastable
		.dq_in(q.sync.dq_s[7:4]),
		.lane_mode(lane_mode),
		.opcode(opcode),
		.addr(addr),
		.bit_count(bits)
	);
	// ==========================================
	// Command decode
	always_comb
	begin
		d = q;
		d.erase_pulse = 1'b0;
		// Clock, select and lane pins pass two flops before any use
		d.sync.sclk_s = {q.sync.sclk_s[0], serial_clk};
		d.sync.csn_s = {q.sync.csn_s[0], chip_sel_n};
		d.sync.dq_s = {q.sync.dq_s[3:0], serial_lane};
		d.sclk_last = q.sync.sclk_s[1];
		d.csn_last = q.sync.csn_s[1];
		abits = 6'h8 + 6'(`WLEC_ADDR_BITS);
		op_only = frame_end && bits == 6'h8;
		addressed = frame_end && bits == abits;
		if (op_only && q.st == wlec_pkg::WLEC_IDLE)
		begin
			case (opcode)
				`WLEC_OP_WREN: d.wel = 1'b1;
				`WLEC_OP_WRDI: d.wel = 1'b0;
				`WLEC_OP_BE:
				begin
					if (q.wel)
					begin
						if (any_sector_locked)
						begin
							d.flags[`WLEC_FLAG_PROT] = 1'b1;
							d.flags[`WLEC_FLAG_EERR] = 1'b1;
						end
						else
						begin
							d.st = wlec_pkg::WLEC_BUSY;
							d.req.kind = wlec_pkg::WLEC_BE;
							d.remain = BE_CYC;
						end
					end
				end
				`WLEC_OP_CLFS: d.flags = `WLEC_FLAG_RESET;
				default: d.wel = q.wel;
			endcase
		end
		else if (addressed && q.st == wlec_pkg::WLEC_IDLE && q.wel &&
			(opcode == `WLEC_OP_SSE || opcode == `WLEC_OP_SE))
		begin
			if (region_protected)
			begin
				d.flags[`WLEC_FLAG_PROT] = 1'b1;
				d.flags[`WLEC_FLAG_EERR] = 1'b1;
			end
			else
			begin
				d.st = wlec_pkg::WLEC_BUSY;
				d.req.addr = addr;
				d.req.kind = (opcode == `WLEC_OP_SSE) ? wlec_pkg::WLEC_SSE : wlec_pkg::WLEC_SE;
				d.remain = (opcode == `WLEC_OP_SSE) ? SSE_CYC : SE_CYC;
			end
		end
		else if (op_only && opcode == `WLEC_OP_SUSP && q.st == wlec_pkg::WLEC_BUSY &&
			q.req.kind != wlec_pkg::WLEC_BE)
		begin
			d.st = wlec_pkg::WLEC_SUSP;
			d.wip = 1'b0;
			d.flags[`WLEC_FLAG_ESUSP] = 1'b1;
			d.flags[`WLEC_FLAG_READY] = 1'b1;
		end
		else if (op_only && opcode == `WLEC_OP_RESM && q.st == wlec_pkg::WLEC_SUSP)
		begin
			d.st = wlec_pkg::WLEC_BUSY;
			d.flags[`WLEC_FLAG_ESUSP] = 1'b0;
		end
		// ==========================================
		// Erase engine
		case (q.st)
			wlec_pkg::WLEC_BUSY:
			begin
				d.wip = 1'b1;
				d.wel = 1'b0;
				d.flags[`WLEC_FLAG_READY] = 1'b0;
				d.age = q.age + 32'h1;
				if (erase_fault || q.age >= TIMEOUT_CYC)
				begin
					d.flags[`WLEC_FLAG_EERR] = 1'b1;
					d.st = wlec_pkg::WLEC_IDLE;
				end
				else if (q.remain <= 32'h1)
				begin
					d.erase_pulse = 1'b1;
					d.st = wlec_pkg::WLEC_IDLE;
				end
				else
					d.remain = q.remain - 32'h1;
			end
			wlec_pkg::WLEC_SUSP:
			begin
				d.wip = 1'b0;
				d.flags[`WLEC_FLAG_READY] = 1'b1;
			end
			default:
			begin
				d.wip = 1'b0;
				d.age = 32'h0;
				d.flags[`WLEC_FLAG_READY] = 1'b1;
			end
		endcase
	end
	// ==========================================
	// Registers
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			q <= '0;
			q.flags <= `WLEC_FLAG_RESET;
			q.sync.csn_s <= 2'h3;
			q.csn_last <= 1'b1;
		end
		else
			q <= d;
	end
	assign write_enable_latch = q.wel;
	assign write_in_progress = q.wip;
	assign flag_status = q.flags;
	assign erase_pulse = q.erase_pulse;
	assign erase_kind = q.req.kind;
	assign erase_addr = q.req.addr;
endmodule : wlec_top

/* File: dv/wlec_host_model.sv */
// Host side serial master model
`timescale 1ns/10ps
module wlec_host_model (
	input wire logic clock,
	output logic serial_clk,
	output logic chip_sel_n,
	output logic [3:0] serial_lane,
	output logic [1:0] lane_mode
);
	// ==========
	// Frame driver
	initial
	begin
		serial_clk = 1'b0;
		chip_sel_n = 1'b1;
		serial_lane = 4'h0;
		lane_mode = 2'h0;
	end
	task automatic frame(input logic [39:0] b, input int n);
		int w;
		w = 1 << lane_mode;
		for (int i = 0; i < n; i += w)
		begin
			@(negedge clock);
			chip_sel_n = 1'b0;
			serial_lane = b[39:36] >> (4 - w);
			b = b << w;
			repeat (4) @(negedge clock);
			serial_clk = 1'b1;
			repeat (4) @(negedge clock);
			serial_clk = 1'b0;
		end
		@(negedge clock);
		chip_sel_n = 1'b1;
		// Released lanes must not keep the last bit
		serial_lane = ~serial_lane;
		repeat (8) @(negedge clock);
	endtask : frame
endmodule : wlec_host_model

/* File: dv/wlec_chk.sv */
// Assertion checker for the write latch and erase sequencer
`timescale 1ns/10ps
module wlec_chk (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic chip_sel_n,
	input wire logic write_enable_latch,
	input wire logic write_in_progress,
	input wire logic [7:0] flag_status,
	input wire logic erase_pulse,
	input wire logic [1:0] erase_kind
);
	// ==========
	// Properties
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	chk_start_clears_latch: assert property ($rose(write_in_progress) |-> !write_enable_latch)
		else $error("latch set at start");
	chk_start_after_frame: assert property ($rose(write_in_progress) |-> chip_sel_n)
		else $error("erase inside frame");
	chk_pulse_single: assert property (erase_pulse |=> !erase_pulse)
		else $error("pulse too long");
	chk_pulse_ends_busy: assert property (erase_pulse |-> ##[0:1] !write_in_progress)
		else $error("busy after done");
	chk_pulse_has_kind: assert property (erase_pulse |-> erase_kind != 2'h0)
		else $error("no kind at done");
	chk_latch_at_select: assert property ($rose(write_enable_latch) |-> chip_sel_n)
		else $error("latch set in frame");
	chk_ready_busy: assert property (write_in_progress && $past(write_in_progress)
		|-> !flag_status[7]) else $error("ready while busy");
	chk_prot_pair: assert property ($rose(flag_status[1]) |-> flag_status[5] && write_enable_latch)
		else $error("protect flags");
	chk_fault_latch: assert property ($rose(flag_status[5]) && !flag_status[1]
		|-> !write_enable_latch) else $error("latch after fault");
endmodule : wlec_chk

/* File: dv/wlec_top_tb_top.sv */
// Testbench for the write latch and erase sequencer
`timescale 1ns/10ps
`include "wlec_defines.svh"
module wlec_top_tb_top;
	// ==========
	// Bench
	localparam int unsigned SSE = 300, SE = 500, BE = 200, TMO = 800;
	logic clock = 1'b0, sys_rst = 1'b1, prot = 1'b0, lock = 1'b0, fault = 1'b0;
	logic sclk, csn, wel, wip, pu, p;
	logic [3:0] lane;
	logic [1:0] md, kd;
	logic [7:0] fl;
	logic [23:0] ea;
	int bad_count = 0, comparisons = 0, c;
	always #10 clock = ~clock;
	wlec_host_model wlec_host_model_inst (.clock(clock), .serial_clk(sclk), .chip_sel_n(csn),
		.serial_lane(lane), .lane_mode(md));
	wlec_top #(.SSE_CYC(SSE), .SE_CYC(SE), .BE_CYC(BE), .TIMEOUT_CYC(TMO)) wlec_top_inst (
		.clock(clock), .sys_rst(sys_rst), .serial_clk(sclk), .chip_sel_n(csn),
		.serial_lane(lane), .lane_mode(md), .region_protected(prot), .any_sector_locked(lock),
		.erase_fault(fault), .write_enable_latch(wel), .write_in_progress(wip),
		.flag_status(fl), .erase_pulse(pu), .erase_kind(kd), .erase_addr(ea));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int n);
		wlec_host_model_inst.frame({op, a, 8'h00}, n);
	endtask : cmd
	task automatic run_out;
		c = 0;
		p = 1'b0;
		while (wip !== 1'b0 && c < 1000)
		begin
			@(negedge clock);
			p = p | pu;
			c++;
		end
	endtask : run_out
	task automatic erase(input logic [7:0] op, input int n, input int cyc, input logic [1:0] k);
		logic [23:0] a;
		a = $urandom;
		cmd(`WLEC_OP_WREN, 0, 8);
		cmd(op, a, n);
		chk("wel", wel, 0);
		chk("wip", wip, 1);
		chk("kind", kd, k);
		if (n > 8) chk("addr", ea, a);
		run_out();
		chk("time", c <= cyc + 2 && c + 12 >= cyc, 1);
		chk("pulse", p, 1);
	endtask : erase
	task automatic wrap_up;
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	initial
	begin
		repeat (90000) @(negedge clock);
		bad_count++;
		wrap_up();
	end
	initial
	begin
		void'($urandom(32'h3fe89d31));
		repeat (20) @(negedge clock);
		sys_rst = 1'b0;
		repeat (4) @(negedge clock);
		chk("flags", fl, 8'h80);
		for (int m = 0; m < 3; m++)
		begin
			wlec_host_model_inst.lane_mode = m[1:0];
			cmd(`WLEC_OP_WREN, 0, 8);
			chk("wel", wel, 1);
			cmd(`WLEC_OP_WRDI, 0, 8 + (1 << m));
			chk("wel", wel, 1);
			cmd(`WLEC_OP_WRDI, 0, 8);
			chk("wel", wel, 0);
			cmd(`WLEC_OP_WREN, 0, 8 + (1 << m));
			chk("wel", wel, 0);
			erase(`WLEC_OP_SSE, 32, SSE, 2'h1);
			erase(`WLEC_OP_SE, 32, SE, 2'h2);
		end
		wlec_host_model_inst.lane_mode = 2'h0;
		cmd(`WLEC_OP_SSE, $urandom, 32);
		chk("wip", {wip, fl}, 9'h080);
		cmd(`WLEC_OP_WREN, 0, 8);
		cmd(`WLEC_OP_SE, $urandom, 24);
		chk("cut", {wel, wip, fl}, 10'h280);
		prot = 1'b1;
		cmd(`WLEC_OP_SE, $urandom, 32);
		chk("prot", {wel, wip, fl}, 10'h2a2);
		cmd(`WLEC_OP_CLFS, 0, 8);
		prot = 1'b0;
		lock = 1'b1;
		cmd(`WLEC_OP_BE, 0, 8);
		chk("lock", {wel, wip, fl}, 10'h2a2);
		cmd(`WLEC_OP_CLFS, 0, 8);
		lock = 1'b0;
		erase(`WLEC_OP_BE, 8, BE, 2'h3);
		fault = $urandom_range(1, 1);
		cmd(`WLEC_OP_WREN, 0, 8);
		cmd(`WLEC_OP_SSE, $urandom, 32);
		run_out();
		chk("fault", {wel, wip, fl[5]}, 3'h1);
		chk("pulse", p, 0);
		fault = 1'b0;
		cmd(`WLEC_OP_CLFS, 0, 8);
		cmd(`WLEC_OP_WREN, 0, 8);
		cmd(`WLEC_OP_SSE, $urandom, 32);
		cmd(`WLEC_OP_SUSP, 0, 8);
		chk("susp", fl[6], 1);
		cmd(`WLEC_OP_RESM, 0, 8);
		chk("resm", {wip, fl[7:6]}, 3'h4);
		run_out();
		chk("pulse", p, 1);
		cmd(`WLEC_OP_RESM, 0, 8);
		chk("idle", wip, 0);
		wrap_up();
	end
endmodule : wlec_top_tb_top
bind wlec_top wlec_chk wlec_chk_inst (.clock(clock), .sys_rst(sys_rst), .chip_sel_n(chip_sel_n),
	.write_enable_latch(write_enable_latch), .write_in_progress(write_in_progress),
	.flag_status(flag_status), .erase_pulse(erase_pulse), .erase_kind(erase_kind));
